/* File: pcdm_map.svh */
// Register offsets, field positions and reset values of the port pin-function mux.
`ifndef PCDM_MAP_SVH
`define PCDM_MAP_SVH

`define PCDM_ADDR_W 8

// Register byte offsets.
`define PCDM_OFS_PCSEL 8'h00
`define PCDM_OFS_PDSEL_LO 8'h04
`define PCDM_OFS_PDSEL_HI 8'h08
`define PCDM_OFS_PA_DATA 8'h0c
`define PCDM_OFS_PA_DIR 8'h10
`define PCDM_OFS_PA_PIN 8'h14
`define PCDM_OFS_PC_DATA 8'h18
`define PCDM_OFS_PC_DIR 8'h1c
`define PCDM_OFS_PC_PIN 8'h20
`define PCDM_OFS_PD_DATA 8'h24
`define PCDM_OFS_PD_DIR 8'h28
`define PCDM_OFS_PD_PIN 8'h2c
`define PCDM_OFS_WAKE_EN 8'h30
`define PCDM_OFS_WAKE_STAT 8'h34
`define PCDM_OFS_BITOP 8'h38

// Low bit of each two-bit selection field.
`define PCDM_PC7_LSB 6
`define PCDM_PC6_LSB 4
`define PCDM_PC5_LSB 2
`define PCDM_PC4_LSB 0
`define PCDM_PD3_LSB 6
`define PCDM_PD2_LSB 4
`define PCDM_PD1_LSB 2
`define PCDM_PD0_LSB 0
`define PCDM_PD6_LSB 4
`define PCDM_PD5_LSB 2
`define PCDM_PD4_LSB 0

// Reset values and implemented-bit mask.
`define PCDM_SEL_RST 8'h00
`define PCDM_PORT_RST 8'hff
`define PCDM_PDSEL_HI_MASK 8'h3f

// Bit-operation command fields.
`define PCDM_BITOP_BIT_LSB 0
`define PCDM_BITOP_DIR 3
`define PCDM_BITOP_VAL 4
`define PCDM_BITOP_PORT_LSB 5

`endif

/* File: pcdm_pkg.sv */
// Types shared by the port pin-function mux modules.
package pcdm_pkg;

    typedef enum logic [1:0] {
        PCDM_FSEL_GPIO = 2'h0,
        PCDM_FSEL_ALT1 = 2'h1,
        PCDM_FSEL_ALT2 = 2'h2,
        PCDM_FSEL_ALT3 = 2'h3
    } pcdm_fsel_type;

    // Values and drive enables offered by the peripherals (enables active high).
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdata_o;
        logic sdata_oe;
        logic sdo_o;
        logic sdo_oe;
        logic std_timer_out;
        logic periodic_timer_out;
        logic lcd_segment_nine;
        logic lcd_segment_ten;
        logic lcd_segment_eleven;
    } pcdm_periph_out_type;

    // Pad levels handed to the peripherals.
    typedef struct packed {
        logic serial_chip_select_n;
        logic sck_i;
        logic sdata_i;
        logic std_timer_clock_in;
        logic std_timer_capture_in;
    } pcdm_periph_in_type;

    // Analog node switches for the LCD bias and charge pump.
    typedef struct packed {
        logic lcd_bias_node;
        logic pump_cap_node_one;
        logic pump_cap_node_two;
    } pcdm_analog_type;

    // Extracts one two-bit selection field.
    function automatic pcdm_fsel_type pcdm_field(input logic [7:0] r, input int lsb);
        return pcdm_fsel_type'(r[lsb +: 2]);
    endfunction

endpackage

/* File: pcdm_wake.sv */
// Port A falling-edge wake-up detector.
`timescale 1ns/1ps
`default_nettype none
`include "pcdm_map.svh"

module pcdm_wake
    import pcdm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pins and control.
    input wire logic [7:0] pa_pad_in,
    input wire logic [7:0] wake_en,
    input wire logic sleep_mode,
    // Events.
    output logic [7:0] fall_ev,
    output logic wake_req
);
    logic [7:0] prev_ff, nxt_prev, ev_ff, nxt_ev;
    logic wake_ff, nxt_wake;

    // Only enabled pins that go high to low while asleep count as wake events.
    always_comb begin
        nxt_prev = pa_pad_in;
        nxt_ev = sleep_mode ? (prev_ff & ~pa_pad_in & wake_en) : 8'h00;
        nxt_wake = |nxt_ev;
    end

    // Previous level resets high so an idle pulled-up pin causes no event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= `PCDM_PORT_RST;
            ev_ff <= 8'h00;
            wake_ff <= 1'b0;
        end else begin
            prev_ff <= nxt_prev;
            ev_ff <= nxt_ev;
            wake_ff <= nxt_wake;
        end
    end

    assign fall_ev = ev_ff;
    assign wake_req = wake_ff;
endmodule
`default_nettype wire

/* File: pcdm_pin_mux.sv */
// Pad routing for port C pins 7..4 and port D pins 6..0.
`timescale 1ns/1ps
`default_nettype none
`include "pcdm_map.svh"

module pcdm_pin_mux
    import pcdm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Selection and general I/O registers.
    input wire logic [7:0] pc_sel,
    input wire logic [7:0] pd_sel_lo,
    input wire logic [7:0] pd_sel_hi,
    input wire logic [7:0] pc_data,
    input wire logic [7:0] pc_dir,
    input wire logic [7:0] pd_data,
    input wire logic [7:0] pd_dir,
    // Pads, bit 0 of the port C group is pin 4.
    input wire logic [3:0] pc_pad_in,
    input wire logic [6:0] pd_pad_in,
    output logic [3:0] pc_pad_out,
    output logic [3:0] pc_pad_oe_n,
    output logic [6:0] pd_pad_out,
    output logic [6:0] pd_pad_oe_n,
    // Peripheral side.
    input wire pcdm_periph_out_type po,
    output pcdm_periph_in_type pi,
    output pcdm_analog_type an
);
    logic [3:0] c_o_ff, c_oen_ff, nxt_c_o, nxt_c_oen;
    logic [6:0] d_o_ff, d_oen_ff, nxt_d_o, nxt_d_oen;
    pcdm_periph_in_type pi_ff, nxt_pi;
    pcdm_analog_type an_ff, nxt_an;
    pcdm_fsel_type s7, s6, s5, s4, d3, d2, d1, d0, d6, d5, d4;

    // General I/O is the default; a selected function takes the pad over.
    always_comb begin
        s7 = pcdm_field(pc_sel, `PCDM_PC7_LSB);
        s6 = pcdm_field(pc_sel, `PCDM_PC6_LSB);
        s5 = pcdm_field(pc_sel, `PCDM_PC5_LSB);
        s4 = pcdm_field(pc_sel, `PCDM_PC4_LSB);
        d3 = pcdm_field(pd_sel_lo, `PCDM_PD3_LSB);
        d2 = pcdm_field(pd_sel_lo, `PCDM_PD2_LSB);
        d1 = pcdm_field(pd_sel_lo, `PCDM_PD1_LSB);
        d0 = pcdm_field(pd_sel_lo, `PCDM_PD0_LSB);
        d6 = pcdm_field(pd_sel_hi, `PCDM_PD6_LSB);
        d5 = pcdm_field(pd_sel_hi, `PCDM_PD5_LSB);
        d4 = pcdm_field(pd_sel_hi, `PCDM_PD4_LSB);
        nxt_c_o = pc_data[7:4];
        nxt_c_oen = pc_dir[7:4];
        nxt_d_o = pd_data[6:0];
        nxt_d_oen = pd_dir[6:0];
        nxt_an = '0;
        // Chip select is an input to the slave; the pad is released.
        nxt_pi.serial_chip_select_n = (s7 == PCDM_FSEL_ALT1) ? pc_pad_in[3] : 1'b1;
        nxt_pi.std_timer_clock_in = (s7 != PCDM_FSEL_ALT1) & pc_pad_in[3];
        if (s7 == PCDM_FSEL_ALT1) nxt_c_oen[3] = 1'b1;
        if (s6 == PCDM_FSEL_ALT1) begin
            nxt_c_o[2] = po.sck_o;
            nxt_c_oen[2] = ~po.sck_oe;
        end
        if (s5 == PCDM_FSEL_ALT1) begin
            nxt_c_o[1] = po.sdata_o;
            nxt_c_oen[1] = ~po.sdata_oe;
        end
        if (s4 == PCDM_FSEL_ALT1) begin
            nxt_c_o[0] = po.sdo_o;
            nxt_c_oen[0] = ~po.sdo_oe;
        end
        unique case (d3)
            PCDM_FSEL_GPIO: ;
            PCDM_FSEL_ALT1: {nxt_d_o[3], nxt_d_oen[3]} = {po.periodic_timer_out, 1'b0};
            PCDM_FSEL_ALT2: {nxt_d_o[3], nxt_d_oen[3]} = {~po.periodic_timer_out, 1'b0};
            PCDM_FSEL_ALT3: {nxt_d_o[3], nxt_d_oen[3]} = {po.sdata_o, ~po.sdata_oe};
        endcase
        if (d2 == PCDM_FSEL_ALT1) {nxt_d_o[2], nxt_d_oen[2]} = {~po.std_timer_out, 1'b0};
        if (d2 == PCDM_FSEL_ALT2) {nxt_d_o[2], nxt_d_oen[2]} = {po.sck_o, ~po.sck_oe};
        if (d1 == PCDM_FSEL_ALT1) {nxt_d_o[1], nxt_d_oen[1]} = {po.std_timer_out, 1'b0};
        if (d0 == PCDM_FSEL_ALT1) {nxt_d_o[0], nxt_d_oen[0]} = {po.periodic_timer_out, 1'b0};
        nxt_pi.std_timer_capture_in = (d0 != PCDM_FSEL_ALT1) & pd_pad_in[0];
        // Analog nodes switch the digital driver off.
        if (d6 == PCDM_FSEL_ALT1)
            {nxt_d_o[6], nxt_d_oen[6]} = {po.lcd_segment_eleven, 1'b0};
        if (d6 == PCDM_FSEL_ALT2) {nxt_d_oen[6], nxt_an.lcd_bias_node} = 2'h3;
        if (d5 == PCDM_FSEL_ALT1) {nxt_d_o[5], nxt_d_oen[5]} = {po.lcd_segment_ten, 1'b0};
        if (d5 == PCDM_FSEL_ALT2) {nxt_d_oen[5], nxt_an.pump_cap_node_two} = 2'h3;
        if (d4 == PCDM_FSEL_ALT1) {nxt_d_o[4], nxt_d_oen[4]} = {po.lcd_segment_nine, 1'b0};
        if (d4 == PCDM_FSEL_ALT2) {nxt_d_oen[4], nxt_an.pump_cap_node_one} = 2'h3;
        // When a shared line is routed to two pins, port C wins the input.
        if (s6 == PCDM_FSEL_ALT1) nxt_pi.sck_i = pc_pad_in[2];
        else if (d2 == PCDM_FSEL_ALT2) nxt_pi.sck_i = pd_pad_in[2];
        else nxt_pi.sck_i = 1'b1;
        if (s5 == PCDM_FSEL_ALT1) nxt_pi.sdata_i = pc_pad_in[1];
        else if (d3 == PCDM_FSEL_ALT3) nxt_pi.sdata_i = pd_pad_in[3];
        else nxt_pi.sdata_i = 1'b1;
    end

    // Pads reset to inputs with the output latch high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_o_ff <= 4'hf;
            c_oen_ff <= 4'hf;
            d_o_ff <= 7'h7f;
            d_oen_ff <= 7'h7f;
            pi_ff <= '1;
            an_ff <= '0;
        end else begin
            c_o_ff <= nxt_c_o;
            c_oen_ff <= nxt_c_oen;
            d_o_ff <= nxt_d_o;
            d_oen_ff <= nxt_d_oen;
            pi_ff <= nxt_pi;
            an_ff <= nxt_an;
        end
    end

    assign pc_pad_out = c_o_ff;
    assign pc_pad_oe_n = c_oen_ff;
    assign pd_pad_out = d_o_ff;
    assign pd_pad_oe_n = d_oen_ff;
    assign pi = pi_ff;
    assign an = an_ff;
endmodule
`default_nettype wire

/* File: pcdm_port_mux.sv */
// Top of the port C/D pin-function mux with APB registers and port A wake-up.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcdm_map.svh"

module pcdm_port_mux
    import pcdm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,

    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PCDM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Port A pads.
    input wire logic [7:0] pa_pad_in,
    output logic [7:0] pa_pad_out,
    output logic [7:0] pa_pad_oe_n,

    // Port C pins 7..4, bit 0 is pin 4.
    input wire logic [3:0] pc_pad_in,
    output logic [3:0] pc_pad_out,
    output logic [3:0] pc_pad_oe_n,

    // Port D pins 6..0.
    input wire logic [6:0] pd_pad_in,
    output logic [6:0] pd_pad_out,
    output logic [6:0] pd_pad_oe_n,

    // Peripherals.
    input wire pcdm_periph_out_type periph_out,
    output pcdm_periph_in_type periph_in,
    output pcdm_analog_type analog_sel,

    // Power management.
    input wire logic sleep_mode,
    output logic wake_req
);

    // Selection registers.
    logic [7:0] pcsel_ff, nxt_pcsel;
    logic [7:0] pdsel_lo_ff, nxt_pdsel_lo;
    logic [7:0] pdsel_hi_ff, nxt_pdsel_hi;

    // General I/O data and direction registers (direction 1 means input).
    logic [7:0] pa_data_ff, nxt_pa_data, pa_dir_ff, nxt_pa_dir;
    logic [7:0] pc_data_ff, nxt_pc_data, pc_dir_ff, nxt_pc_dir;
    logic [7:0] pd_data_ff, nxt_pd_data, pd_dir_ff, nxt_pd_dir;

    // Wake-up control and sticky status.
    logic [7:0] wake_en_ff, nxt_wake_en, wake_stat_ff, nxt_wake_stat;
    logic [7:0] fall_ev;

    // Port A pad drivers.
    logic [7:0] pa_o_ff, nxt_pa_o, pa_oen_ff, nxt_pa_oen;

    // Bus answer.
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;

    // Decode helpers.
    logic setup, wr_en, hit;
    logic [7:0] rd, pc_pins, pd_pins, src, res;
    logic [1:0] bop_port;
    logic [2:0] bop_bit;
    logic bop_dir, bop_val;

    // Returns the value with one bit forced to the requested level.
    function automatic logic [7:0] pcdm_bit_put(input logic [7:0] v, input logic [2:0] b,
                                                input logic val);
        logic [7:0] r;

        r = v;
        r[b] = val;
        return r;
    endfunction

    // Pin images of the whole ports; bits outside this block read from the latch.
    assign pc_pins = {pc_pad_in, pc_data_ff[3:0]};
    assign pd_pins = {pd_data_ff[7], pd_pad_in};

    // Transfer phases; the answer is always ready in the first access cycle.
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready_ff;

    // Bit operation fields.
    assign bop_port = pwdata[`PCDM_BITOP_PORT_LSB +: 2];
    assign bop_bit = pwdata[`PCDM_BITOP_BIT_LSB +: 3];
    assign bop_dir = pwdata[`PCDM_BITOP_DIR];
    assign bop_val = pwdata[`PCDM_BITOP_VAL];

    // Read decode; the address is held from setup through access.
    always_comb begin
        // An unlisted offset answers with an error and reads as zero.
        hit = 1'b1;
        rd = 8'h00;
        case (paddr)
            `PCDM_OFS_PCSEL: rd = pcsel_ff;
            `PCDM_OFS_PDSEL_LO: rd = pdsel_lo_ff;
            `PCDM_OFS_PDSEL_HI: rd = pdsel_hi_ff & `PCDM_PDSEL_HI_MASK;
            `PCDM_OFS_PA_DATA: rd = pa_data_ff;
            `PCDM_OFS_PA_DIR: rd = pa_dir_ff;
            `PCDM_OFS_PA_PIN: rd = pa_pad_in;
            `PCDM_OFS_PC_DATA: rd = pc_data_ff;
            `PCDM_OFS_PC_DIR: rd = pc_dir_ff;
            `PCDM_OFS_PC_PIN: rd = pc_pins;
            `PCDM_OFS_PD_DATA: rd = pd_data_ff;
            `PCDM_OFS_PD_DIR: rd = pd_dir_ff;
            `PCDM_OFS_PD_PIN: rd = pd_pins;
            `PCDM_OFS_WAKE_EN: rd = wake_en_ff;
            `PCDM_OFS_WAKE_STAT: rd = wake_stat_ff;
            `PCDM_OFS_BITOP: rd = 8'h00;
            default: hit = 1'b0;
        endcase
    end

    // Bit operation: the source is the port's pin image or its direction register.
    always_comb begin
        unique case (bop_port)
            2'h0: src = bop_dir ? pa_dir_ff : pa_pad_in;
            2'h1: src = bop_dir ? pc_dir_ff : pc_pins;
            2'h2: src = bop_dir ? pd_dir_ff : pd_pins;
            default: src = 8'h00;
        endcase

        res = pcdm_bit_put(src, bop_bit, bop_val);
    end

    // Register writes and the bus answer.
    always_comb begin
        nxt_pcsel = pcsel_ff;
        nxt_pdsel_lo = pdsel_lo_ff;
        nxt_pdsel_hi = pdsel_hi_ff;
        nxt_pa_data = pa_data_ff;
        nxt_pa_dir = pa_dir_ff;
        nxt_pc_data = pc_data_ff;
        nxt_pc_dir = pc_dir_ff;
        nxt_pd_data = pd_data_ff;
        nxt_pd_dir = pd_dir_ff;
        nxt_wake_en = wake_en_ff;
        nxt_wake_stat = wake_stat_ff;

        // Zero wait states: the answer stands in the first access cycle only.
        nxt_pready = setup;
        nxt_pslverr = setup & ~hit;
        nxt_prdata = (setup & ~pwrite & hit) ? {24'h000000, rd} : 32'h00000000;

        // A write lands only at the access edge that sees pready, so exactly once.
        if (wr_en) begin
            case (paddr)
                `PCDM_OFS_PCSEL: nxt_pcsel = pwdata[7:0];
                `PCDM_OFS_PDSEL_LO: nxt_pdsel_lo = pwdata[7:0];
                `PCDM_OFS_PDSEL_HI: nxt_pdsel_hi = pwdata[7:0] & `PCDM_PDSEL_HI_MASK;
                `PCDM_OFS_PA_DATA: nxt_pa_data = pwdata[7:0];
                `PCDM_OFS_PA_DIR: nxt_pa_dir = pwdata[7:0];
                `PCDM_OFS_PC_DATA: nxt_pc_data = pwdata[7:0];
                `PCDM_OFS_PC_DIR: nxt_pc_dir = pwdata[7:0];
                `PCDM_OFS_PD_DATA: nxt_pd_data = pwdata[7:0];
                `PCDM_OFS_PD_DIR: nxt_pd_dir = pwdata[7:0];
                `PCDM_OFS_WAKE_EN: nxt_wake_en = pwdata[7:0];
                `PCDM_OFS_WAKE_STAT: nxt_wake_stat = wake_stat_ff & ~pwdata[7:0];
                `PCDM_OFS_BITOP: begin
                    // The whole byte is written back, so other output latches
                    // may pick up pin levels; a known cost of whole-port writes.
                    unique case ({bop_port, bop_dir})
                        3'h0: nxt_pa_data = res;
                        3'h1: nxt_pa_dir = res;
                        3'h2: nxt_pc_data = res;
                        3'h3: nxt_pc_dir = res;
                        3'h4: nxt_pd_data = res;
                        3'h5: nxt_pd_dir = res;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end

        // A new falling edge beats a clear in the same cycle.
        nxt_wake_stat = nxt_wake_stat | fall_ev;
    end

    // Port A pads follow the latch and direction registers.
    always_comb begin
        nxt_pa_o = pa_data_ff;
        nxt_pa_oen = pa_dir_ff;
    end

    // Register stage for all control state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcsel_ff <= `PCDM_SEL_RST;
            pdsel_lo_ff <= `PCDM_SEL_RST;
            pdsel_hi_ff <= `PCDM_SEL_RST;

            pa_data_ff <= `PCDM_PORT_RST;
            pa_dir_ff <= `PCDM_PORT_RST;
            pc_data_ff <= `PCDM_PORT_RST;
            pc_dir_ff <= `PCDM_PORT_RST;
            pd_data_ff <= `PCDM_PORT_RST;
            pd_dir_ff <= `PCDM_PORT_RST;

            // Wake-up stays off until software enables a pin.
            wake_en_ff <= 8'h00;
            wake_stat_ff <= 8'h00;

            // Port A pads come up released, with the latch high.
            pa_o_ff <= `PCDM_PORT_RST;
            pa_oen_ff <= `PCDM_PORT_RST;

            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pcsel_ff <= nxt_pcsel;
            pdsel_lo_ff <= nxt_pdsel_lo;
            pdsel_hi_ff <= nxt_pdsel_hi;

            pa_data_ff <= nxt_pa_data;
            pa_dir_ff <= nxt_pa_dir;
            pc_data_ff <= nxt_pc_data;
            pc_dir_ff <= nxt_pc_dir;
            pd_data_ff <= nxt_pd_data;
            pd_dir_ff <= nxt_pd_dir;

            wake_en_ff <= nxt_wake_en;
            wake_stat_ff <= nxt_wake_stat;

            pa_o_ff <= nxt_pa_o;
            pa_oen_ff <= nxt_pa_oen;

            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Pin routing for ports C and D; pads start as inputs latched high.
    pcdm_pin_mux u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .pc_sel(pcsel_ff),
        .pd_sel_lo(pdsel_lo_ff),
        .pd_sel_hi(pdsel_hi_ff),
        .pc_data(pc_data_ff),
        .pc_dir(pc_dir_ff),
        .pd_data(pd_data_ff),
        .pd_dir(pd_dir_ff),
        .pc_pad_in(pc_pad_in),
        .pd_pad_in(pd_pad_in),
        .pc_pad_out(pc_pad_out),
        .pc_pad_oe_n(pc_pad_oe_n),
        .pd_pad_out(pd_pad_out),
        .pd_pad_oe_n(pd_pad_oe_n),
        .po(periph_out),
        .pi(periph_in),
        .an(analog_sel)
    );

    // Port A wake-up detector.
    pcdm_wake u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .pa_pad_in(pa_pad_in),
        .wake_en(wake_en_ff),
        .sleep_mode(sleep_mode),
        .fall_ev(fall_ev),
        .wake_req(wake_req)
    );

    // Every output comes straight from a flip-flop.
    assign pa_pad_out = pa_o_ff;
    assign pa_pad_oe_n = pa_oen_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule
`default_nettype wire

/* File: pcdm_periph_model.sv */
// Behavioural peripheral side that feeds the pin-function mux.
`timescale 1ns/1ps
`default_nettype none
module pcdm_periph_model
    import pcdm_pkg::*;
(
    // Level chosen by the bench.
    input wire logic lvl,
    // Mux side.
    input wire pcdm_periph_in_type periph_in,
    output wire pcdm_periph_out_type periph_out
);
    // Enables stay high, so a selected pad must show the level and its polarity.
    assign periph_out = {lvl, 1'b1, lvl, 1'b1, lvl, 1'b1, lvl, lvl, lvl, lvl, lvl};
endmodule
`default_nettype wire

/* File: pcdm_port_mux_monitor.sv */
// Port-level checker for the pin-function mux.
`timescale 1ns/1ps
`default_nettype none
`include "pcdm_map.svh"
module pcdm_port_mux_monitor
    import pcdm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PCDM_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Pads, peripherals and wake-up.
    input wire logic [7:0] pa_pad_in,
    input wire logic [7:0] pa_pad_oe_n,
    input wire logic [3:0] pc_pad_oe_n,
    input wire logic [6:0] pd_pad_oe_n,
    input wire pcdm_periph_in_type periph_in,
    input wire pcdm_analog_type analog_sel,
    input wire logic sleep_mode,
    input wire logic wake_req
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_rst_in;
        $rose(presetn) |-> &{pa_pad_oe_n, pc_pad_oe_n, pd_pad_oe_n};
    endproperty
    a_rst_in: assert property (p_rst_in) else $error("pin driven after reset");
    property p_hi_rd;
        psel && penable && pready && !pwrite && paddr == `PCDM_OFS_PDSEL_HI
            |-> prdata[7:6] == 2'h0;
    endproperty
    a_hi_rd: assert property (p_hi_rd) else $error("upper bits read nonzero");
    property p_cs_idle;
        !pc_pad_oe_n[3] |-> periph_in.serial_chip_select_n;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("select active on driven pin");
    property p_bias;
        analog_sel.lcd_bias_node |-> pd_pad_oe_n[6];
    endproperty
    a_bias: assert property (p_bias) else $error("bias node pad driven");
    property p_pump2;
        analog_sel.pump_cap_node_two |-> pd_pad_oe_n[5];
    endproperty
    a_pump2: assert property (p_pump2) else $error("pump node two pad driven");
    property p_pump1;
        analog_sel.pump_cap_node_one |-> pd_pad_oe_n[4];
    endproperty
    a_pump1: assert property (p_pump1) else $error("pump node one pad driven");
    // A wake needs a one-to-zero step two samples back while sleeping.
    property p_wake;
        wake_req |-> $past(sleep_mode) && |($past(pa_pad_in, 2) & ~$past(pa_pad_in));
    endproperty
    a_wake: assert property (p_wake) else $error("wake without a fall");
    property p_awake;
        !$past(sleep_mode) |-> !wake_req;
    endproperty
    a_awake: assert property (p_awake) else $error("wake while running");
    c_wake: cover property (wake_req);
    c_bias: cover property (analog_sel.lcd_bias_node);
    c_cs: cover property (pc_pad_oe_n[3] && !periph_in.serial_chip_select_n);
endmodule

bind pcdm_port_mux pcdm_port_mux_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pa_pad_in(pa_pad_in),
    .pa_pad_oe_n(pa_pad_oe_n), .pc_pad_oe_n(pc_pad_oe_n), .pd_pad_oe_n(pd_pad_oe_n),
    .periph_in(periph_in), .analog_sel(analog_sel), .sleep_mode(sleep_mode),
    .wake_req(wake_req)
);
`default_nettype wire

/* File: test_pcdm_port_mux.sv */
// Self-checking bench for the pin-function mux.
`timescale 1ns/1ps
`default_nettype none
`include "pcdm_map.svh"
module test_pcdm_port_mux
    import pcdm_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0, lvl = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pa_pad_in = 8'hff;
    logic [3:0] pc_pad_in = 4'h0;
    logic [6:0] pd_pad_in = 7'h55;
    logic [31:0] prdata, rd;
    logic pready, pslverr, wake_req, err;
    logic [7:0] pa_pad_out, pa_pad_oe_n, s;
    logic [3:0] pc_pad_out, pc_pad_oe_n;
    logic [6:0] pd_pad_out, pd_pad_oe_n;
    pcdm_periph_out_type periph_out;
    pcdm_periph_in_type periph_in;
    pcdm_analog_type analog_sel;
    logic [3:0] t0 [4] = '{4'h0, 4'h4, 4'h8, 4'h0};
    logic [3:0] t1 [4] = '{4'h0, 4'hb, 4'h4, 4'h8};
    logic [7:0] rst_tbl [12] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h0f, 8'hff, 8'hff, 8'hd5};
    logic [4:0] pin_tbl [4] = '{5'h1d, 5'h00, 5'h1d, 5'h19};
    int miscompares = 0, samples_checked = 0, n;

    pcdm_port_mux dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_pad_in(pa_pad_in), .pa_pad_out(pa_pad_out),
        .pa_pad_oe_n(pa_pad_oe_n), .pc_pad_in(pc_pad_in), .pc_pad_out(pc_pad_out),
        .pc_pad_oe_n(pc_pad_oe_n), .pd_pad_in(pd_pad_in), .pd_pad_out(pd_pad_out),
        .pd_pad_oe_n(pd_pad_oe_n), .periph_out(periph_out), .periph_in(periph_in),
        .analog_sel(analog_sel), .sleep_mode(sleep_mode), .wake_req(wake_req));
    pcdm_periph_model peri_u (.lvl(lvl), .periph_in(periph_in), .periph_out(periph_out));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    // Main sequence; pads settle one edge after the register edge, so two edges are waited.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rchk(8'(4 * i), rst_tbl[i]);
        end
        $display("test reset values done");
        apb(1'b1, `PCDM_OFS_PDSEL_HI, 8'hff);
        rchk(`PCDM_OFS_PDSEL_HI, 8'h3f);
        apb(1'b0, 8'h3c, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test register access done");
        apb(1'b1, `PCDM_OFS_PD_DIR, 8'h00);
        apb(1'b1, `PCDM_OFS_PC_DIR, 8'h00);
        repeat (2) @(posedge pclk);
        chk(32'(pd_pad_out), 32'h7f);
        chk(32'(pd_pad_oe_n), 32'h0);
        chk(32'(pc_pad_out), 32'hf);
        $display("test output default done");
        apb(1'b1, `PCDM_OFS_PC_DATA, 8'h00);
        apb(1'b1, `PCDM_OFS_PD_DATA, 8'h00);
        // Every code on every pin, with the peripheral level low and then high.
        for (int l = 0; l < 2; l++) begin
            lvl <= l[0];
            for (int c = 0; c < 4; c++) begin
                s = {4{c[1:0]}};
                apb(1'b1, `PCDM_OFS_PCSEL, s);
                apb(1'b1, `PCDM_OFS_PDSEL_LO, s);
                apb(1'b1, `PCDM_OFS_PDSEL_HI, s);
                repeat (2) @(posedge pclk);
                chk(32'(pd_pad_out[3:0]), 32'(l[0] ? t1[c] : t0[c]));
                chk(32'(pc_pad_oe_n), c == 1 ? 32'h8 : 32'h0);
                chk(32'(pc_pad_out[2:0]), c == 1 ? 32'({3{l[0]}}) : 32'h0);
                chk(32'(periph_in.serial_chip_select_n), 32'(c != 1));
                chk(32'(periph_in), 32'(pin_tbl[c]));
                chk(32'(analog_sel), c == 2 ? 32'h7 : 32'h0);
                chk(32'(pd_pad_oe_n[6:4]), c == 2 ? 32'h7 : 32'h0);
                if (c != 2)
                    chk(32'(pd_pad_out[6:4]), c == 1 ? 32'({3{l[0]}}) : 32'h0);
            end
        end
        $display("test function select done");
        apb(1'b1, `PCDM_OFS_BITOP, 8'h51);
        rchk(`PCDM_OFS_PD_DATA, 8'h57);
        apb(1'b1, `PCDM_OFS_BITOP, 8'h08);
        rchk(`PCDM_OFS_PA_DIR, 8'hfe);
        chk(32'({pa_pad_out[0], pa_pad_oe_n}), 32'h1fe);
        $display("test bit operation done");
        apb(1'b1, `PCDM_OFS_WAKE_EN, 8'h01);
        sleep_mode <= 1'b1;
        pa_pad_in <= 8'hfd;
        repeat (4) @(posedge pclk);
        rchk(`PCDM_OFS_WAKE_STAT, 8'h00);
        pa_pad_in <= 8'hfc;
        n = 0;
        while (wake_req !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < 10), 32'h1);
        rchk(`PCDM_OFS_WAKE_STAT, 8'h01);
        apb(1'b1, `PCDM_OFS_WAKE_STAT, 8'h01);
        rchk(`PCDM_OFS_WAKE_STAT, 8'h00);
        $display("test wake-up done");
        summarize();
    end
endmodule
`default_nettype wire
